// ===== src/rtcw_map.vh
// Constants for the clock/calendar two-wire slave with access watchdog
`ifndef RTCW_MAP_VH
`define RTCW_MAP_VH

// ----------------------------------------
// Slave addresses and byte layout
// ----------------------------------------
`define RTCW_ADDR_RD      8'hA3
`define RTCW_ADDR_WR      8'hA2
`define RTCW_RW_BIT       0
`define RTCW_MSB          7
`define RTCW_NEXT_MSB     6
`define RTCW_BYTE_BITS    4'h8
`define RTCW_PTR_W        4
`define RTCW_DATA_W       8
`define RTCW_WR_W         12
`define RTCW_PTR_RESET    4'h0
`define RTCW_FIFO_DEPTH   4
`define RTCW_FIFO_CW      3

// ----------------------------------------
// Watchdog timing
// ----------------------------------------
`define RTCW_CLK_MHZ      100
`define RTCW_WD_TIME_MS   1000
`define RTCW_WD_CYC       (`RTCW_WD_TIME_MS * 1000 * `RTCW_CLK_MHZ)
`define RTCW_WD_W         28

// ----------------------------------------
// Interface states
// ----------------------------------------
`define RTCW_ST_IDLE      3'h0
`define RTCW_ST_ADDR      3'h1
`define RTCW_ST_ACK       3'h2
`define RTCW_ST_WRX       3'h3
`define RTCW_ST_TX        3'h4
`define RTCW_ST_RACK      3'h5
`define RTCW_ST_IGNORE    3'h6

`endif

// ===== src/rtcw_fifo.v
// Shift-out FIFO with registered head, valid and ready on both sides
`timescale 1ns/100ps
`include "rtcw_map.vh"
module rtcw_fifo #(
    parameter WIDTH = `RTCW_WR_W,
    parameter DEPTH = `RTCW_FIFO_DEPTH,
    parameter CW    = `RTCW_FIFO_CW
) (
    // Clock, reset, enable
    input  wire             clk_i,
    input  wire             reset_n_i,
    input  wire             ce_i,
    input  wire             clr_i,
    // Fill side
    input  wire             in_valid_i,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             in_ready_o,
    // Drain side
    output wire             out_valid_o,
    output wire [WIDTH-1:0] out_data_o,
    input  wire             out_ready_i
);

    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [CW-1:0]    cnt_r;
    reg              valid_r;
    reg              full_r;
    wire             push;
    wire             pop;
    wire [CW-1:0]    cnt_nxt;
    wire [CW-1:0]    last_idx;
    integer          i;

    assign push        = in_valid_i & ~full_r;
    assign pop         = valid_r & out_ready_i;
    assign cnt_nxt     = cnt_r + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop};
    assign last_idx    = cnt_r - {{(CW-1){1'b0}}, 1'b1};
    assign in_ready_o  = ~full_r;
    assign out_valid_o = valid_r;
    assign out_data_o  = mem[0];

    // Head always sits in slot 0, so the drain side sees flops
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r   <= {CW{1'b0}};
            valid_r <= 1'b0;
            full_r  <= 1'b0;
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= {WIDTH{1'b0}};
            end
        end else if (ce_i) begin
            if (clr_i) begin
                cnt_r   <= {CW{1'b0}};
                valid_r <= 1'b0;
                full_r  <= 1'b0;
            end else begin
                for (i = 0; i < DEPTH; i = i + 1) begin
                    if (push && ((pop && i == last_idx) || (!pop && i == cnt_r))) begin
                        mem[i] <= in_data_i;
                    end else if (pop && i < DEPTH - 1) begin
                        mem[i] <= mem[i+1];
                    end
                end
                cnt_r   <= cnt_nxt;
                valid_r <= (cnt_nxt != {CW{1'b0}});
                full_r  <= (cnt_nxt == DEPTH[CW-1:0]);
            end
        end
    end

endmodule

// ===== src/rtcw_i2c_slave.v
// Two-wire slave interface of a clock/calendar with access watchdog
`timescale 1ns/100ps
`include "rtcw_map.vh"
module rtcw_i2c_slave #(
    parameter [31:0] WD_CYC = `RTCW_WD_CYC
) (
    // Clock, reset, enable
    input  wire                   clk_i,
    input  wire                   reset_n_i,
    input  wire                   ce_i,
    input  wire                   rst_int_i,
    // Bus pins
    input  wire                   scl_i,
    input  wire                   sda_i,
    output wire                   sda_o,
    output wire                   sda_oe_o,
    // Register file read side
    output wire [`RTCW_PTR_W-1:0] rd_addr_o,
    input  wire [`RTCW_DATA_W-1:0] rd_data_i,
    // Register file write stream
    output wire                   wr_valid_o,
    output wire [`RTCW_WR_W-1:0]  wr_data_o,
    input  wire                   wr_ready_i,
    // Timekeeping control
    output wire                   freeze_o,
    output wire                   lose_sec_o
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam [`RTCW_WD_W-1:0] WD_LAST = WD_CYC[`RTCW_WD_W-1:0] - 1'b1;

    reg  [1:0]               scl_sync_r;
    reg  [1:0]               sda_sync_r;
    reg                      scl_d_r;
    reg                      sda_d_r;
    reg  [2:0]               state_r;
    reg  [3:0]               bit_cnt_r;
    reg  [`RTCW_DATA_W-1:0]  shift_r;
    reg  [`RTCW_PTR_W-1:0]   ptr_r;
    reg                      ptr_set_r;
    reg                      rd_mode_r;
    reg                      mack_r;
    reg                      drive_r;
    reg                      sda_lvl_r;
    reg                      freeze_r;
    reg  [`RTCW_WD_W-1:0]    wd_cnt_r;
    reg                      lose_r;
    reg                      pend_r;
    reg  [`RTCW_WR_W-1:0]    pend_data_r;
    wire                     scl_s;
    wire                     sda_s;
    wire                     scl_rise;
    wire                     scl_fall;
    wire                     start_det;
    wire                     stop_det;
    wire                     fifo_rdy;
    wire                     room;
    wire                     addr_ok;
    wire                     wd_fire;

    // ----------------------------------------
    // Pin synchronisers and line events
    // ----------------------------------------
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r    <= 1'b1;
            sda_d_r    <= 1'b1;
        end else if (ce_i) begin
            scl_sync_r <= {scl_sync_r[0], scl_i};
            sda_sync_r <= {sda_sync_r[0], sda_i};
            scl_d_r    <= scl_sync_r[1];
            sda_d_r    <= sda_sync_r[1];
        end
    end

    assign scl_s     = scl_sync_r[1];
    assign sda_s     = sda_sync_r[1];
    assign scl_rise  = scl_s & ~scl_d_r;
    assign scl_fall  = ~scl_s & scl_d_r;
    // Clock held high across both samples
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    assign addr_ok  = (shift_r == `RTCW_ADDR_WR) || (shift_r == `RTCW_ADDR_RD);
    assign room     = ~pend_r | fifo_rdy;
    assign wd_fire  = freeze_r & (wd_cnt_r == WD_LAST);

    // ----------------------------------------
    // Interface sequencer
    // ----------------------------------------
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r     <= `RTCW_ST_IDLE;
            bit_cnt_r   <= 4'h0;
            shift_r     <= 8'h00;
            ptr_r       <= `RTCW_PTR_RESET;
            ptr_set_r   <= 1'b0;
            rd_mode_r   <= 1'b0;
            mack_r      <= 1'b0;
            drive_r     <= 1'b0;
            sda_lvl_r   <= 1'b0;
            freeze_r    <= 1'b0;
            wd_cnt_r    <= {`RTCW_WD_W{1'b0}};
            lose_r      <= 1'b0;
            pend_r      <= 1'b0;
            pend_data_r <= 12'h000;
        end else if (ce_i) begin
            lose_r    <= 1'b0;
            sda_lvl_r <= 1'b0;
            if (pend_r && fifo_rdy) begin
                pend_r <= 1'b0;
            end
            // Watchdog runs only while counters are held
            if (freeze_r) begin
                wd_cnt_r <= wd_cnt_r + 1'b1;
            end else begin
                wd_cnt_r <= {`RTCW_WD_W{1'b0}};
            end

            if (rst_int_i) begin
                // Silent and reinitialised while held
                state_r   <= `RTCW_ST_IDLE;
                ptr_r     <= `RTCW_PTR_RESET;
                ptr_set_r <= 1'b0;
                drive_r   <= 1'b0;
                freeze_r  <= 1'b0;
                bit_cnt_r <= 4'h0;
                pend_r    <= 1'b0;
            end else if (wd_fire) begin
                // Hung access: drop the bus, let time run
                state_r   <= `RTCW_ST_IDLE;
                drive_r   <= 1'b0;
                freeze_r  <= 1'b0;
                ptr_set_r <= 1'b0;
                lose_r    <= 1'b1;
            end else if (stop_det) begin
                state_r   <= `RTCW_ST_IDLE;
                drive_r   <= 1'b0;
                freeze_r  <= 1'b0;
                ptr_set_r <= 1'b0;
            end else if (start_det) begin
                // Repeated start keeps the freeze
                state_r   <= `RTCW_ST_ADDR;
                drive_r   <= 1'b0;
                bit_cnt_r <= 4'h0;
                shift_r   <= 8'h00;
            end else begin
                case (state_r)
                    `RTCW_ST_ADDR, `RTCW_ST_WRX: begin
                        if (scl_rise) begin
                            // Sample on rising clock, line stable while high
                            shift_r   <= {shift_r[`RTCW_NEXT_MSB:0], sda_s};
                            bit_cnt_r <= bit_cnt_r + 1'b1;
                        end else if (scl_fall && bit_cnt_r == `RTCW_BYTE_BITS) begin
                            bit_cnt_r <= 4'h0;
                            if (state_r == `RTCW_ST_ADDR) begin
                                if (addr_ok) begin
                                    state_r   <= `RTCW_ST_ACK;
                                    drive_r   <= 1'b1;
                                    freeze_r  <= 1'b1;
                                    wd_cnt_r  <= {`RTCW_WD_W{1'b0}};
                                    rd_mode_r <= shift_r[`RTCW_RW_BIT];
                                    ptr_set_r <= ~shift_r[`RTCW_RW_BIT];
                                end else begin
                                    state_r <= `RTCW_ST_IGNORE;
                                end
                            end else if (ptr_set_r) begin
                                ptr_r     <= shift_r[`RTCW_PTR_W-1:0];
                                ptr_set_r <= 1'b0;
                                drive_r   <= 1'b1;
                                state_r   <= `RTCW_ST_ACK;
                            end else if (room) begin
                                pend_r      <= 1'b1;
                                pend_data_r <= {ptr_r, shift_r};
                                ptr_r       <= ptr_r + 1'b1;
                                drive_r     <= 1'b1;
                                state_r     <= `RTCW_ST_ACK;
                            end else begin
                                // Stream still blocked: refuse the byte
                                state_r <= `RTCW_ST_IGNORE;
                            end
                        end
                    end
                    `RTCW_ST_ACK: begin
                        // Low held through the whole ninth clock high
                        if (scl_fall) begin
                            if (rd_mode_r) begin
                                shift_r   <= rd_data_i;
                                drive_r   <= ~rd_data_i[`RTCW_MSB];
                                bit_cnt_r <= 4'h1;
                                state_r   <= `RTCW_ST_TX;
                            end else begin
                                drive_r <= 1'b0;
                                state_r <= `RTCW_ST_WRX;
                            end
                        end
                    end
                    `RTCW_ST_TX: begin
                        // Change data only after clock falls
                        if (scl_fall) begin
                            if (bit_cnt_r == `RTCW_BYTE_BITS) begin
                                drive_r <= 1'b0;
                                state_r <= `RTCW_ST_RACK;
                            end else begin
                                drive_r   <= ~shift_r[`RTCW_NEXT_MSB];
                                shift_r   <= {shift_r[`RTCW_NEXT_MSB:0], 1'b0};
                                bit_cnt_r <= bit_cnt_r + 1'b1;
                            end
                        end
                    end
                    `RTCW_ST_RACK: begin
                        if (scl_rise) begin
                            mack_r <= ~sda_s;
                            ptr_r  <= ptr_r + 1'b1;
                        end else if (scl_fall) begin
                            if (mack_r) begin
                                shift_r   <= rd_data_i;
                                drive_r   <= ~rd_data_i[`RTCW_MSB];
                                bit_cnt_r <= 4'h1;
                                state_r   <= `RTCW_ST_TX;
                            end else begin
                                // Master ended the read; line left high
                                drive_r <= 1'b0;
                                state_r <= `RTCW_ST_IGNORE;
                            end
                        end
                    end
                    `RTCW_ST_IGNORE: begin
                        drive_r <= 1'b0;
                    end
                    `RTCW_ST_IDLE: begin
                        drive_r <= 1'b0;
                    end
                    default: begin
                        state_r <= `RTCW_ST_IDLE;
                        drive_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Write stream buffer
    // ----------------------------------------
    rtcw_fifo #(
        .WIDTH (`RTCW_WR_W),
        .DEPTH (`RTCW_FIFO_DEPTH),
        .CW    (`RTCW_FIFO_CW)
    ) u_wr_fifo (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .ce_i        (ce_i),
        .clr_i       (rst_int_i),
        .in_valid_i  (pend_r),
        .in_data_i   (pend_data_r),
        .in_ready_o  (fifo_rdy),
        .out_valid_o (wr_valid_o),
        .out_data_o  (wr_data_o),
        .out_ready_i (wr_ready_i)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Open drain: only ever pulls low, clock never driven
    assign sda_o      = sda_lvl_r;
    assign sda_oe_o   = drive_r;
    assign rd_addr_o  = ptr_r;
    assign freeze_o   = freeze_r;
    assign lose_sec_o = lose_r;

endmodule

// ===== tb/rtcw_props.sv
// Checker of the two-wire slave ports, with its bind
`timescale 1ns/100ps
`include "rtcw_map.vh"
module rtcw_props #(
    parameter [31:0] WD_CYC = `RTCW_WD_CYC
) (
    // Clock and resets
    input wire                   clk_i,
    input wire                   reset_n_i,
    input wire                   rst_int_i,
    // Bus and streams
    input wire                   scl_i,
    input wire                   sda_o,
    input wire                   sda_oe_o,
    input wire [`RTCW_PTR_W-1:0] rd_addr_o,
    input wire                   wr_valid_o,
    input wire [`RTCW_WR_W-1:0]  wr_data_o,
    input wire                   wr_ready_i,
    input wire                   freeze_o,
    input wire                   lose_sec_o
);
    // ----------------------------------------
    // Length of the current freeze
    // ----------------------------------------
    reg [31:0] frz_cnt_r;
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            frz_cnt_r <= 32'h0;
        end else begin
            frz_cnt_r <= freeze_o ? frz_cnt_r + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_scl_high4;
        scl_i [*4];
    endsequence
    sequence s_wd_expiry;
        lose_sec_o ##1 !lose_sec_o;
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_sda_value: assert property (sda_o == 1'b0)
        else $error("data output not low");
    a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i || lose_sec_o || $past(lose_sec_o) || $past(rst_int_i))
        else $error("data enable moved while clock high");
    a_ack_stable: assert property (sda_oe_o && $rose(scl_i) |-> sda_oe_o throughout s_scl_high4)
        else $error("data low not held over clock high");
    a_freeze_rise: assert property ($rose(freeze_o) |-> !scl_i && sda_oe_o && !$past(sda_oe_o))
        else $error("freeze rose without address ack");
    a_wd_pulse: assert property (lose_sec_o |-> s_wd_expiry)
        else $error("lose second pulse too long");
    a_wd_not_early: assert property (lose_sec_o |-> $past(frz_cnt_r) + 32'h2 >= WD_CYC)
        else $error("watchdog fired early");
    a_wd_not_late: assert property (frz_cnt_r <= 2 * WD_CYC)
        else $error("freeze outlived watchdog");
    a_wd_release: assert property (lose_sec_o |-> ##[0:1] (!freeze_o && !sda_oe_o))
        else $error("watchdog left access open");
    a_int_reset: assert property ($past(rst_int_i) |-> !freeze_o && !sda_oe_o && rd_addr_o == `RTCW_PTR_RESET && !wr_valid_o)
        else $error("internal reset did not clear bus logic");
    a_wr_hold: assert property (wr_valid_o && !wr_ready_i && !rst_int_i |=> wr_valid_o && $stable(wr_data_o))
        else $error("write word dropped before taken");
endmodule

bind rtcw_i2c_slave rtcw_props #(.WD_CYC(WD_CYC)) i_props (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .rst_int_i(rst_int_i), .scl_i(scl_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .rd_addr_o(rd_addr_o), .wr_valid_o(wr_valid_o), .wr_data_o(wr_data_o),
    .wr_ready_i(wr_ready_i), .freeze_o(freeze_o), .lose_sec_o(lose_sec_o)
);

// ===== tb/rtcw_mst.sv
// Two-wire bus master model, link clock of 125 ns
`timescale 1ns/100ps
module rtcw_mst (
    // Bus pins
    output reg  scl_o,
    output reg  sda_low_o,
    input  wire sda_i
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task bit_w(input b);
        begin
            sda_low_o = !b;
            #31;
            scl_o = 1'b1;
            #62.5;
            scl_o = 1'b0;
            #31.5;
        end
    endtask
    task bit_r(output b);
        begin
            sda_low_o = 1'b0;
            #31;
            scl_o = 1'b1;
            #31;
            b = sda_i;
            #31.5;
            scl_o = 1'b0;
            #31.5;
        end
    endtask
    task start;
        begin
            sda_low_o = 1'b0;
            #31;
            scl_o = 1'b1;
            #31;
            sda_low_o = 1'b1;
            #31.5;
            scl_o = 1'b0;
            #31.5;
        end
    endtask
    task stop;
        begin
            sda_low_o = 1'b1;
            #31;
            scl_o = 1'b1;
            #31;
            sda_low_o = 1'b0;
            #63;
        end
    endtask
    task wbyte(input [7:0] d, output ack);
        integer i;
        reg     s;
        begin
            for (i = 7; i >= 0; i = i - 1) bit_w(d[i]);
            bit_r(s);
            ack = !s;
        end
    endtask
    task rbyte(input last, output [7:0] d);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) bit_r(d[i]);
            bit_w(last);
        end
    endtask
endmodule

// ===== tb/test_i2c_rtc_slave_watchdog.sv
// Self-checking bench of the two-wire clock/calendar slave
`timescale 1ns/100ps
`include "rtcw_map.vh"
module test_i2c_rtc_slave_watchdog;
    localparam [31:0] WD_CYC = 32'd2000;
    localparam int    TMO    = 20000;
    reg                    clk_i, reset_n_i, ce_i, rst_int_i, wr_ready_i, stall;
    wire                   scl, m_low, sda_o, sda_oe_o, wr_valid_o, freeze_o, lose_sec_o;
    wire                   sda = (sda_oe_o ? sda_o : 1'b1) & !m_low;
    wire [`RTCW_PTR_W-1:0] rd_addr_o;
    wire [`RTCW_DATA_W-1:0] rd_data_i;
    wire [`RTCW_WR_W-1:0]  wr_data_o;
    logic [7:0]            regs [0:15];
    logic [7:0]            shadow [0:15];
    logic [11:0]           q [$];
    logic [7:0]            addrs [6] = '{8'hA2, 8'hA0, 8'hA6, 8'h22, 8'hE2, 8'hA1};
    logic                  a;
    logic [7:0]            d;
    int                    n_errors = 0, compares = 0, cyc = 0, k;
    assign rd_data_i = regs[rd_addr_o];
    rtcw_i2c_slave #(.WD_CYC(WD_CYC)) i_dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .rst_int_i(rst_int_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
        .wr_valid_o(wr_valid_o), .wr_data_o(wr_data_o), .wr_ready_i(wr_ready_i), .freeze_o(freeze_o),
        .lose_sec_o(lose_sec_o));
    rtcw_mst i_mst (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // ----------------------------------------
    // Checks, verdict, scoreboard
    // ----------------------------------------
    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (exp !== got) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task finish_test;
        if (n_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(negedge clk_i) begin
        cyc++;
        if (cyc == TMO) begin
            n_errors++;
            finish_test;
        end
        if (reset_n_i && wr_valid_o === 1'b1 && wr_ready_i) begin
            chk("write word", q.size() > 0 ? q.pop_front() : 16'hFFFF, wr_data_o);
            regs[wr_data_o[11:8]] = wr_data_o[7:0];
        end
    end
    always @(posedge clk_i) begin
        #1;
        wr_ready_i = !stall && ($urandom % 2 == 1);
    end
    task wr_seq(input [7:0] ptr_b, input int n);
        logic [3:0] p;
        i_mst.start;
        i_mst.wbyte(`RTCW_ADDR_WR, a);
        chk("write address ack", 1'h1, a);
        i_mst.wbyte(ptr_b, a);
        chk("pointer ack", 1'h1, a);
        repeat (4) @(posedge clk_i);
        chk("pointer", ptr_b[3:0], rd_addr_o);
        chk("freeze in access", 1'h1, freeze_o);
        p = ptr_b[3:0];
        repeat (n) begin
            d = $urandom;
            q.push_back({p, d});
            shadow[p] = d;
            i_mst.wbyte(d, a);
            chk("data ack", 1'h1, a);
            p++;
        end
    endtask
    task drain;
        k = 0;
        while (q.size() > 0 && k < 500) begin
            @(posedge clk_i);
            k++;
        end
        chk("pending words", 16'h0, q.size());
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        reset_n_i = 1'b0;
        ce_i = 1'b1;
        rst_int_i = 1'b0;
        wr_ready_i = 1'b0;
        stall = 1'b0;
        for (int i = 0; i < 16; i++) regs[i] = 8'h00;
        void'($urandom(32'h3e48));
        repeat (4) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        repeat (3) @(posedge clk_i);
        chk("reset freeze", 1'h0, freeze_o);
        chk("reset pointer", 4'h0, rd_addr_o);
        chk("reset data enable", 1'h0, sda_oe_o);
        wr_seq({4'($urandom), 4'hE}, 4);
        i_mst.stop;
        repeat (4) @(posedge clk_i);
        chk("pointer after write", 4'h2, rd_addr_o);
        chk("freeze after stop", 1'h0, freeze_o);
        drain;
        stall = 1'b1;
        wr_seq(8'h03, 5);
        i_mst.wbyte(8'h5A, a);
        chk("ack with full buffer", 1'h0, a);
        i_mst.stop;
        stall = 1'b0;
        drain;
        i_mst.start;
        i_mst.wbyte(`RTCW_ADDR_WR, a);
        i_mst.wbyte(8'h7E, a);
        i_mst.start;
        i_mst.wbyte(`RTCW_ADDR_RD, a);
        chk("read address ack", 1'h1, a);
        for (int i = 0; i < 3; i++) begin
            i_mst.rbyte(i == 2, d);
            chk("read data", shadow[4'(14 + i)], d);
        end
        repeat (4) @(posedge clk_i);
        chk("released after last read", 1'h0, sda_oe_o);
        i_mst.stop;
        repeat (4) @(posedge clk_i);
        chk("pointer after read", 4'h1, rd_addr_o);
        foreach (addrs[i]) begin
            i_mst.start;
            i_mst.wbyte(addrs[i], a);
            chk("address ack", addrs[i] == `RTCW_ADDR_WR, a);
            i_mst.wbyte(8'h00, a);
            chk("ack after address", addrs[i] == `RTCW_ADDR_WR, a);
            chk("freeze by address", addrs[i] == `RTCW_ADDR_WR, freeze_o);
            i_mst.stop;
        end
        i_mst.start;
        i_mst.wbyte(`RTCW_ADDR_WR, a);
        i_mst.wbyte(8'h09, a);
        @(posedge clk_i);
        #1 rst_int_i = 1'b1;
        i_mst.start;
        i_mst.wbyte(`RTCW_ADDR_WR, a);
        chk("ack in internal reset", 1'h0, a);
        chk("pointer in internal reset", 4'h0, rd_addr_o);
        chk("freeze in internal reset", 1'h0, freeze_o);
        @(posedge clk_i);
        #1 rst_int_i = 1'b0;
        i_mst.stop;
        i_mst.start;
        i_mst.wbyte(`RTCW_ADDR_WR, a);
        k = 0;
        while (lose_sec_o !== 1'b1 && k < 3 * WD_CYC) begin
            @(posedge clk_i);
            #2;
            k++;
        end
        // Count starts one acknowledge bit after the address ended
        chk("watchdog delay", 1'h1, k + 20 >= WD_CYC && k <= WD_CYC);
        repeat (2) @(posedge clk_i);
        chk("freeze after watchdog", 1'h0, freeze_o);
        i_mst.stop;
        drain;
        finish_test;
    end
endmodule
